// ===== rtl/sslp_pkg.sv
// package for the synthesizer serial latch programming port
package sslp_pkg;
  // ****************************************
  // word layout
  // ****************************************
  localparam int WORD_W = 24;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 2;
  localparam int CRST_POS = 2;  // counter_reset_bit
  localparam int SPD_POS = 3;   // soft_powerdown_bit
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FBK = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [23:0] LATCH_RST = 24'h000000;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int BIAS_SETTLE_US = 1;
  localparam int BIAS_SETTLE_CYC = BIAS_SETTLE_US * CLK_MHZ;
  localparam logic [7:0] SETTLE_CNT = 8'(BIAS_SETTLE_CYC);

  typedef struct packed {
    logic [23:0] ref_word;
    logic [23:0] fbk_word;
    logic [23:0] func_word;
  } sslp_latches_t;
endpackage : sslp_pkg

// ===== rtl/sslp_top.sv
// serial latch programming port with power-down and counter-reset control
`timescale 1ns/10ps
`default_nettype none
module sslp_top (
  // clock and reset
  input  wire logic                  CORE_CLK,
  input  wire logic                  SYS_RST,
  // serial pins from host
  input  wire logic                  SER_CLK,
  input  wire logic                  SER_DATA,
  input  wire logic                  LOAD_STROBE,
  input  wire logic                  CHIP_EN,
  // latch contents and control
  output var sslp_pkg::sslp_latches_t LATCHES,
  output logic                       POWERED_DOWN,
  output logic                       COUNTERS_RESET,
  output logic                       OUTPUT_ACTIVE,
  output logic                       BIAS_SETTLED
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] prev;
  // first stage read only by the second stage
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      prev  <= 3'h0;
    end else begin
      sync1 <= {LOAD_STROBE, SER_DATA, SER_CLK};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  wire sclk_rise   = sync2[0] & ~prev[0];
  wire sdata       = sync2[1];
  wire strobe_rise = sync2[2] & ~prev[2];

  // ****************************************
  // input register
  // ****************************************
  logic [23:0] shreg;
  // shift per rising edge; msb first so select bits land in the lsbs
  // no power-down term here, shifting keeps going
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shreg <= sslp_pkg::LATCH_RST;
    end else if (sclk_rise) begin
      shreg <= {shreg[22:0], sdata};
    end
  end

  wire [1:0] sel    = shreg[sslp_pkg::SEL_LSB +: sslp_pkg::SEL_W];
  // strobe rise decodes select; code 11 matches none
  wire       ld_ref  = strobe_rise & (sel == sslp_pkg::SEL_REF);
  wire       ld_fbk  = strobe_rise & (sel == sslp_pkg::SEL_FBK);
  wire       ld_func = strobe_rise & (sel == sslp_pkg::SEL_FUNC);

  // ****************************************
  // latches
  // ****************************************
  logic [2:0] written;
  // latches reset only with system reset, never by chip enable
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      LATCHES <= '{default: sslp_pkg::LATCH_RST};
      written <= 3'h0;
    end else begin
      if (ld_ref) LATCHES.ref_word <= shreg;
      if (ld_fbk) LATCHES.fbk_word <= shreg;
      if (ld_func) LATCHES.func_word <= shreg;
      written <= written | {ld_func, ld_fbk, ld_ref};
    end
  end

  // ****************************************
  // power-down and counter control
  // ****************************************
  // chip enable gates combinationally, no clock needed
  wire soft_pd = LATCHES.func_word[sslp_pkg::SPD_POS];
  assign POWERED_DOWN = ~CHIP_EN | soft_pd;
  // counters held by the counter_reset_bit or power-down
  // one shared release so both counters restart together
  assign COUNTERS_RESET = LATCHES.func_word[sslp_pkg::CRST_POS] | POWERED_DOWN;
  // inactive until all three latches written
  assign OUTPUT_ACTIVE = (&written) & ~POWERED_DOWN;

  // bias settle timer, informational; the pin itself is async so it is synchronised here
  logic ce_s1;
  logic ce_s2;
  logic [7:0] settle;
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ce_s1  <= 1'b0;
      ce_s2  <= 1'b0;
      settle <= 8'h00;
    end else begin
      ce_s1  <= CHIP_EN;
      ce_s2  <= ce_s1;
      settle <= !ce_s2 ? 8'h00 : (settle == sslp_pkg::SETTLE_CNT ? settle : settle + 8'h01);
    end
  end
  assign BIAS_SETTLED = (settle == sslp_pkg::SETTLE_CNT);

  // ****************************************
  // assertions
  // ****************************************
  // shifting: one bit per synchronised serial rise, msb first
  property p_shift;
    @(posedge CORE_CLK) disable iff (SYS_RST) sclk_rise |=> shreg[0] == $past(sdata);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bit lost");
  property p_msb;
    @(posedge CORE_CLK) disable iff (SYS_RST) sclk_rise |=> shreg[23:1] == $past(shreg[22:0]);
  endproperty
  a_msb: assert property (p_msb) else $error("shift order wrong");
  // power-down must leave the shift path running
  property p_pdshift;
    @(posedge CORE_CLK) disable iff (SYS_RST) (POWERED_DOWN && sclk_rise) |=> shreg[0] == $past(sdata);
  endproperty
  a_pdshift: assert property (p_pdshift) else $error("shift stopped in power-down");

  // loading: select codes 00, 01 and 10 each land in their own latch only
  property p_load;
    @(posedge CORE_CLK) disable iff (SYS_RST) ld_ref |=> LATCHES.ref_word == $past(shreg);
  endproperty
  a_load: assert property (p_load) else $error("reference load wrong");
  property p_loadfbk;
    @(posedge CORE_CLK) disable iff (SYS_RST) ld_fbk |=> LATCHES.fbk_word == $past(shreg);
  endproperty
  a_loadfbk: assert property (p_loadfbk) else $error("feedback load wrong");
  property p_loadfunc;
    @(posedge CORE_CLK) disable iff (SYS_RST) ld_func |=> LATCHES.func_word == $past(shreg);
  endproperty
  a_loadfunc: assert property (p_loadfunc) else $error("function load wrong");
  property p_pdload;
    @(posedge CORE_CLK) disable iff (SYS_RST) (POWERED_DOWN && ld_fbk) |=> LATCHES.fbk_word == $past(shreg);
  endproperty
  a_pdload: assert property (p_pdload) else $error("load lost in power-down");
  // code 11 is a dead load: neither data nor the written mask moves
  property p_sel11;
    @(posedge CORE_CLK) disable iff (SYS_RST) (strobe_rise && sel == 2'h3) |=> $stable(LATCHES);
  endproperty
  a_sel11: assert property (p_sel11) else $error("code 11 wrote a latch");
  property p_ld11;
    @(posedge CORE_CLK) disable iff (SYS_RST) (strobe_rise && sel == 2'h3) |=> written == $past(written);
  endproperty
  a_ld11: assert property (p_ld11) else $error("code 11 marked a latch written");
  // latches hold between loads, chip enable or not
  property p_keep;
    @(posedge CORE_CLK) disable iff (SYS_RST) (!strobe_rise) |=> $stable(LATCHES);
  endproperty
  a_keep: assert property (p_keep) else $error("latch changed without load");

  // power-down and counter hold
  property p_pd;
    @(posedge CORE_CLK) disable iff (SYS_RST) !CHIP_EN |-> POWERED_DOWN && !OUTPUT_ACTIVE;
  endproperty
  a_pd: assert property (p_pd) else $error("not powered down");
  property p_crst;
    @(posedge CORE_CLK) disable iff (SYS_RST) LATCHES.func_word[2] |-> COUNTERS_RESET;
  endproperty
  a_crst: assert property (p_crst) else $error("counters not held");
  property p_crstpd;
    @(posedge CORE_CLK) disable iff (SYS_RST) POWERED_DOWN |-> COUNTERS_RESET;
  endproperty
  a_crstpd: assert property (p_crstpd) else $error("counters run in power-down");

  // output enable: three latches written and not powered down
  property p_act;
    @(posedge CORE_CLK) disable iff (SYS_RST) OUTPUT_ACTIVE |-> written == 3'h7;
  endproperty
  a_act: assert property (p_act) else $error("active too early");
  // a rise needs a fresh load or a power-down release one edge before
  property p_actrise;
    @(posedge CORE_CLK) disable iff (SYS_RST) $rose(OUTPUT_ACTIVE) |-> $past(strobe_rise) || $past(POWERED_DOWN);
  endproperty
  a_actrise: assert property (p_actrise) else $error("output woke without cause");

  // bias timer restarts with every chip-enable drop
  property p_settle;
    @(posedge CORE_CLK) disable iff (SYS_RST) !ce_s2 |=> !BIAS_SETTLED;
  endproperty
  a_settle: assert property (p_settle) else $error("settle flag kept after disable");
  property p_settlehold;
    @(posedge CORE_CLK) disable iff (SYS_RST) (ce_s2 && settle == sslp_pkg::SETTLE_CNT) |=> BIAS_SETTLED;
  endproperty
  a_settlehold: assert property (p_settlehold) else $error("settle flag dropped while enabled");

  // ****************************************
  // coverage
  // ****************************************
  // main scenarios: loads, power-down, counter hold, dead code
  c_func: cover property (@(posedge CORE_CLK) ld_func);
  c_active: cover property (@(posedge CORE_CLK) OUTPUT_ACTIVE);
  c_pdload: cover property (@(posedge CORE_CLK) POWERED_DOWN && ld_fbk);
  c_crst: cover property (@(posedge CORE_CLK) COUNTERS_RESET && !POWERED_DOWN);
  c_sel11: cover property (@(posedge CORE_CLK) strobe_rise && sel == 2'h3);
endmodule : sslp_top
`default_nettype wire

// ===== dv/sslp_host.sv
// host serial master model for the programming pins
`timescale 1ns/10ps
`default_nettype none
module sslp_host (
  // serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // msb first, three bytes, 160 ns
  task automatic send(input logic [23:0] w);
    load_strobe = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      ser_data = w[i];
      #80 ser_clk = 1'b1;
      #80 ser_clk = 1'b0;
    end
    ser_data = ~w[0]; // released line must not look stable
    #80 load_strobe = 1'b1;
    #160 load_strobe = 1'b0;
  endtask : send
endmodule : sslp_host
`default_nettype wire

// ===== dv/sslp_top_tb_top.sv
// self-checking bench for the serial latch programming port
`timescale 1ns/10ps
`default_nettype none
module sslp_top_tb_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, pd, cr, act, bs;
  wire sck, sda, lds;
  sslp_pkg::sslp_latches_t lat;
  logic [23:0] exp [3] = '{default: 24'h0};
  logic [2:0] wm = 3'h0;
  int err_total = 0, tests_run = 0, seed = 32'h190a41d0, cyc = 0;
  always #10 clk = ~clk;
  sslp_host sslp_host_inst (.ser_clk(sck), .ser_data(sda), .load_strobe(lds));
  sslp_top sslp_top_inst (.CORE_CLK(clk), .SYS_RST(rst), .SER_CLK(sck), .SER_DATA(sda), .LOAD_STROBE(lds),
    .CHIP_EN(ce), .LATCHES(lat), .POWERED_DOWN(pd), .COUNTERS_RESET(cr), .OUTPUT_ACTIVE(act), .BIAS_SETTLED(bs));
  task automatic check(input string n, input logic [23:0] seen, input logic [23:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, want, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  function automatic logic [23:0] mk(input logic [1:0] s, input logic c, input logic p);
    mk = {20'($random(seed)), p, c, s};
  endfunction : mk
  // one write, then every latch and the pd, crst and act flags against the model
  task automatic wr(input logic [23:0] w);
    logic pe;
    sslp_host_inst.send(w);
    repeat (8) @(negedge clk);
    if (w[1:0] != 2'h3) begin
      exp[w[1:0]] = w;
      wm[w[1:0]] = 1'b1;
    end
    pe = ~ce | exp[2][3];
    check("ref", lat.ref_word, exp[0]);
    check("fbk", lat.fbk_word, exp[1]);
    check("func", lat.func_word, exp[2]);
    check("pd", 24'(pd), 24'(pe));
    check("crst", 24'(cr), 24'(exp[2][2] | pe));
    check("act", 24'(act), 24'(&wm & ~pe));
    $display("test done word %h", w);
  endtask : wr
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("act0", 24'(act), 24'h0);
    wr(mk(2'h2, 1'b0, 1'b0));
    wr(mk(2'h0, 1'b0, 1'b0));
    wr(mk(2'h1, 1'b0, 1'b0));
    wr(mk(2'h3, 1'b1, 1'b1));
    ce = 1'b0;
    #1 check("pdnow", 24'(pd), 24'h1);
    @(negedge clk);
    wr(mk(2'h0, 1'b0, 1'b0));
    ce = 1'b1;
    repeat (sslp_pkg::BIAS_SETTLE_CYC) @(negedge clk);
    check("bs0", 24'(bs), 24'h0);
    repeat (4) @(negedge clk);
    check("bs1", 24'(bs), 24'h1);
    wr(mk(2'h1, 1'b0, 1'b0));
    wr(mk(2'h2, 1'b1, 1'b0));
    wr(mk(2'h0, 1'b0, 1'b0));
    wr(mk(2'h1, 1'b0, 1'b0));
    wr(mk(2'h2, 1'b0, 1'b0));
    for (int i = 0; i < 12; i++) wr(24'($random(seed)));
    complete_run();
  end
endmodule : sslp_top_tb_top
`default_nettype wire
